//--- hdl/host_port_pkg.sv
// Purpose: shared constants for the 8-bit host port and its chip control pins
// Assumes: everything sampled on mclk (50 MHz); pins synchronous to mclk
// Notes:   used by the device end, the host end and the bench
//
// Behaviour
// - select 1: latch pin is ALE, falling edge
// - select 0: latch pin is address strobe
// - chip select low enables; high ignored
// - muxed internal select matches AD[6:4] to strap
// - unused internal select: address inputs held low
// - interrupt high on unmasked alarm, regs 0/1
// - select 1: ready high when done
// - handshake tristated while chip select high
// - select 0: acknowledge low when done
// - muxed bus: address on low four lines
// - separate bus: address from four inputs
// - host clock between 2x line and 16.384 MHz; mclk here runs at 50 MHz
// - rate select 0: reference at sixteen times
// - rate select 1: reference at line rate
// - reference clock continuous, gapless, jitter free
// - lost flag high while reference absent
// - hardware reset clears line path state
// - hardware reset held low at least 10 us
// - test pin tristates set chosen by reg4 bit3
// - select 1 separate rd/wr; 0 strobe plus direction
// - direction line high read, low write
// - strobe style write loads on strobe low
`default_nettype none
package host_port_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 4;
  localparam int          NUM_REGS     = 16;
  localparam int          CLK_MHZ      = 50;
  // register map positions used by the device logic
  localparam logic [3:0]  REG_ALARM0   = 4'h0;
  localparam logic [3:0]  REG_ALARM1   = 4'h1;
  localparam logic [3:0]  REG_MASK0    = 4'h2;
  localparam logic [3:0]  REG_MASK1    = 4'h3;
  localparam logic [3:0]  REG_TEST     = 4'h4;
  localparam logic [3:0]  REG_CTRL     = 4'h5;
  localparam int          TEST_SET_BIT = 3;
  localparam int          RATE_SEL_BIT = 1;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  // reference clock watchdog, in mclk cycles of no reference edge
  localparam int          REF_LOST_CYC = 64;
  // host-side bus phase timing
  localparam int          RESET_MIN_US = 10;
  localparam int          RESET_CYC    = RESET_MIN_US * CLK_MHZ;
  localparam int          PHASE_CYC    = 2;
  // host command register offsets (AXI4-Lite, byte addresses)
  localparam logic [7:0]  CMD_OFS      = 8'h00;
  localparam logic [7:0]  WDATA_OFS    = 8'h04;
  localparam logic [7:0]  RDATA_OFS    = 8'h08;
  localparam logic [7:0]  STAT_OFS     = 8'h0C;
  localparam logic [7:0]  MODE_OFS     = 8'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage
`default_nettype wire

//--- hdl/host_port_if.sv
// Purpose: pin bundle between the host processor and the line device
// Assumes: one clock; every three-signal pin is resolved here
// Notes:   wire level is high when nobody drives (pull-ups on the board)
`default_nettype none
interface host_port_if;
  logic       strobeStyleSelect;
  logic       busMultiplexSelect;
  logic       chipSelN;
  logic       addressLatchStrobe;
  logic       writeOrDataStrobe;
  logic       readOrDirection;
  logic [3:0] addrIn;
  logic [7:0] busHostOut;
  logic [7:0] busHostOe;
  logic [7:0] busDevOut;
  logic [7:0] busDevOe;
  logic [7:0] busLevel;
  logic       handshakeOut;
  logic       handshakeOe;
  logic       handshakeLevel;
  logic       interruptOut;
  logic       hwResetN;

  // resolved levels: driven value, else pulled high
  genvar g;
  for (g = 0; g < 8; g++) begin : g_bus
    assign busLevel[g] = busDevOe[g] ? busDevOut[g] : (busHostOe[g] ? busHostOut[g] : 1'b1);
  end
  assign handshakeLevel = handshakeOe ? handshakeOut : 1'b1;

  modport device (
    input  strobeStyleSelect, busMultiplexSelect, chipSelN, addressLatchStrobe,
    input  writeOrDataStrobe, readOrDirection, addrIn, busLevel, hwResetN,
    output busDevOut, busDevOe, handshakeOut, handshakeOe, interruptOut
  );
  modport host (
    output strobeStyleSelect, busMultiplexSelect, chipSelN, addressLatchStrobe,
    output writeOrDataStrobe, readOrDirection, addrIn, busHostOut, busHostOe, hwResetN,
    input  busLevel, handshakeLevel, interruptOut
  );
endinterface
`default_nettype wire

//--- hdl/line_device_port.sv
// Purpose: device end of the host port, register file, alarms, reference watch
// Assumes: host pins synchronous to mclk; recoveryReferenceClock is sampled
// Notes:   register contents beyond alarms, masks and test/rate bits are plain storage
`default_nettype none
module line_device_port #(
  parameter int REF_LOST = host_port_pkg::REF_LOST_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  host_port_if.device hp,
  input  wire logic [7:0] alarmEvent,
  input  wire logic [1:0] alarmBank,
  input  wire logic [2:0] deviceAddress,
  input  wire logic recoveryReferenceClock,
  input  wire logic in_circuit_test_n,
  output logic referenceClockLost,
  output logic referenceRateSelect,
  output logic testTristateSetSelect,
  output logic lineStateClear,
  output logic outputsTristated
);
  initial begin
    if (REF_LOST < 2 || REF_LOST > 65535) $error("REF_LOST out of range");
  end

  // ************************************************************
  // pin decode and edge detection
  // ************************************************************
  logic       latchPrev_ff;
  logic       strobePrev_ff;
  logic       readPrev_ff;
  logic       selected;
  logic       latchFall;
  logic       strobeFall;
  logic       readFall;
  logic [3:0] latchedAddr_ff;
  logic       addrMatch_ff;
  logic [3:0] nxt_addr;
  logic       nxt_match;
  logic       strapSelect;
  logic       writeReq;
  logic       readReq;
  logic       isReadCycle;

  // both strobe styles latch on the falling edge of the shared pin
  assign latchFall   = latchPrev_ff & ~hp.addressLatchStrobe;
  assign strobeFall  = strobePrev_ff & ~hp.writeOrDataStrobe;
  assign readFall    = readPrev_ff & ~hp.readOrDirection;
  // internal select only in muxed mode with A3 strapped high
  assign strapSelect = hp.busMultiplexSelect & hp.addrIn[3];
  assign nxt_addr    = hp.busMultiplexSelect ? hp.busLevel[3:0] : hp.addrIn;
  assign nxt_match   = ~strapSelect | (hp.busLevel[6:4] == deviceAddress);
  assign selected    = ~hp.chipSelN & addrMatch_ff;
  // style 1: separate read and write; style 0: data strobe plus direction
  assign isReadCycle = hp.strobeStyleSelect ? ~hp.readOrDirection
                                            : (hp.readOrDirection & ~hp.writeOrDataStrobe);
  assign writeReq    = selected & (hp.strobeStyleSelect ? strobeFall
                                                        : (strobeFall & ~hp.readOrDirection));
  assign readReq     = selected & (hp.strobeStyleSelect ? readFall
                                                        : (strobeFall & hp.readOrDirection));

  // edge history for the strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latchPrev_ff  <= 1'b1;
      strobePrev_ff <= 1'b1;
      readPrev_ff   <= 1'b1;
    end else begin
      latchPrev_ff  <= hp.addressLatchStrobe;
      strobePrev_ff <= hp.writeOrDataStrobe;
      readPrev_ff   <= hp.readOrDirection;
    end
  end

  // address phase capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latchedAddr_ff <= '0;
      addrMatch_ff   <= 1'b0;
    end else if (latchFall) begin
      latchedAddr_ff <= nxt_addr;
      addrMatch_ff   <= nxt_match;
    end
  end

  // ************************************************************
  // register file and alarm flags
  // ************************************************************
  logic [7:0] regs_ff [host_port_pkg::NUM_REGS];
  logic [7:0] alarmBits0;
  logic [7:0] alarmBits1;

  // alarm sets win over a host write in the same cycle
  assign alarmBits0 = alarmBank[0] ? alarmEvent : 8'h00;
  assign alarmBits1 = alarmBank[1] ? alarmEvent : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < host_port_pkg::NUM_REGS; i++) regs_ff[i] <= host_port_pkg::REG_RESET;
    end else begin
      for (int i = 0; i < host_port_pkg::NUM_REGS; i++) begin
        if (writeReq && latchedAddr_ff == 4'(i)) regs_ff[i] <= hp.busLevel;
      end
      // alarm flags are write-one-to-clear, set has priority
      if (writeReq && latchedAddr_ff == host_port_pkg::REG_ALARM0)
        regs_ff[host_port_pkg::REG_ALARM0] <= (regs_ff[host_port_pkg::REG_ALARM0] & ~hp.busLevel) | alarmBits0;
      else
        regs_ff[host_port_pkg::REG_ALARM0] <= regs_ff[host_port_pkg::REG_ALARM0] | alarmBits0;
      if (writeReq && latchedAddr_ff == host_port_pkg::REG_ALARM1)
        regs_ff[host_port_pkg::REG_ALARM1] <= (regs_ff[host_port_pkg::REG_ALARM1] & ~hp.busLevel) | alarmBits1;
      else
        regs_ff[host_port_pkg::REG_ALARM1] <= regs_ff[host_port_pkg::REG_ALARM1] | alarmBits1;
    end
  end

  // ************************************************************
  // bus outputs: data, handshake, interrupt
  // ************************************************************
  logic [7:0] busOut_ff;
  logic       busOe_ff;
  logic       done_ff;
  logic       hsOut_ff;
  logic       hsOe_ff;
  logic       irq_ff;
  logic       readActive;
  logic       nxt_irq;

  // a read stays open while its strobe is low; bus released otherwise
  assign readActive = selected & isReadCycle;
  assign nxt_irq    = |(regs_ff[host_port_pkg::REG_ALARM0] & ~regs_ff[host_port_pkg::REG_MASK0])
                    | |(regs_ff[host_port_pkg::REG_ALARM1] & ~regs_ff[host_port_pkg::REG_MASK1]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busOut_ff <= '0;
      busOe_ff  <= 1'b0;
      done_ff   <= 1'b0;
      hsOut_ff  <= 1'b1;
      hsOe_ff   <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      busOut_ff <= regs_ff[latchedAddr_ff];
      busOe_ff  <= readActive & in_circuit_test_n;
      // done stays set until the strobes return high
      if (writeReq || readReq) done_ff <= 1'b1;
      else if (hp.writeOrDataStrobe && (hp.readOrDirection || !hp.strobeStyleSelect)) done_ff <= 1'b0;
      hsOut_ff  <= hp.strobeStyleSelect ? (done_ff | writeReq | readReq)
                                        : ~(done_ff | writeReq | readReq);
      // on a strap mismatch the shared handshake is left to the addressed device
      hsOe_ff   <= ~hp.chipSelN & (~strapSelect | addrMatch_ff) & in_circuit_test_n;
      irq_ff    <= nxt_irq;
    end
  end

  assign hp.busDevOut    = busOut_ff;
  assign hp.busDevOe     = {8{busOe_ff}};
  assign hp.handshakeOut = hsOut_ff;
  assign hp.handshakeOe  = hsOe_ff;
  assign hp.interruptOut = irq_ff;

  // ************************************************************
  // reference clock watch, rate and test selects, reset view
  // ************************************************************
  logic        refS1_ff;
  logic        refS2_ff;
  logic        refPrev_ff;
  logic [15:0] refIdle_ff;
  logic        lost_ff;
  logic        rate_ff;
  logic        testSet_ff;
  logic        clear_ff;
  logic        tri_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refS1_ff   <= 1'b0;
      refS2_ff   <= 1'b0;
      refPrev_ff <= 1'b0;
      refIdle_ff <= '0;
      lost_ff    <= 1'b1;
      rate_ff    <= 1'b0;
      testSet_ff <= 1'b0;
      clear_ff   <= 1'b1;
      tri_ff     <= 1'b0;
    end else begin
      refS1_ff   <= recoveryReferenceClock;
      refS2_ff   <= refS1_ff;
      refPrev_ff <= refS2_ff;
      if (refS2_ff != refPrev_ff) refIdle_ff <= '0;
      else if (refIdle_ff != 16'(REF_LOST)) refIdle_ff <= refIdle_ff + 16'h0001;
      lost_ff    <= (refIdle_ff == 16'(REF_LOST));
      rate_ff    <= regs_ff[host_port_pkg::REG_CTRL][host_port_pkg::RATE_SEL_BIT];
      testSet_ff <= regs_ff[host_port_pkg::REG_TEST][host_port_pkg::TEST_SET_BIT];
      clear_ff   <= ~hp.hwResetN;
      tri_ff     <= ~in_circuit_test_n;
    end
  end

  assign referenceClockLost    = lost_ff;
  assign referenceRateSelect   = rate_ff;
  assign testTristateSetSelect = testSet_ff;
  assign lineStateClear        = clear_ff;
  assign outputsTristated      = tri_ff;
endmodule
`default_nettype wire

//--- hdl/host_bus_master.sv
// Purpose: host end; AXI4-Lite command registers drive 8-bit bus cycles
// Assumes: one write or one read outstanding on AXI; inputs synchronous to mclk
// Notes:   start by writing CMD; STAT bit0 busy, bit1 done, bit2 interrupt level
`default_nettype none
module host_bus_master #(
  parameter int PHASE = host_port_pkg::PHASE_CYC,
  parameter int RST_CYC = host_port_pkg::RESET_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  host_port_if.host        hp,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  initial begin
    if (PHASE < 1 || PHASE > 255 || RST_CYC < host_port_pkg::RESET_CYC || RST_CYC > 65535) $error("bad timing parameter");
  end

  typedef enum logic [2:0] {IDLE = 3'b000, ADDR = 3'b001, LATCH = 3'b011, STROBE = 3'b010,
                            DONE = 3'b110, RST = 3'b111} st_t;
  st_t         st_ff;
  logic [15:0] cnt_ff;
  logic [3:0]  addr_ff;
  logic [7:0]  wdat_ff;
  logic [7:0]  rdat_ff;
  logic        rd_ff;
  logic [3:0]  mode_ff; // bit0 style, bit1 mux, bit2 chip-select strap, bit3 unused
  logic [2:0]  devAddr_ff;
  logic        done_ff;
  logic        awSeen_ff;
  logic        wSeen_ff;
  logic [7:0]  awa_ff;
  logic [31:0] wd_ff;
  logic        cntZero;
  logic        hsSeen;
  logic        wrGo;
  logic        useStrap;

  assign cntZero  = (cnt_ff == 16'h0000);
  assign hsSeen   = hp.strobeStyleSelect ? hp.handshakeLevel : ~hp.handshakeLevel;
  assign wrGo     = awSeen_ff & wSeen_ff & ~s_axi_bvalid;
  assign useStrap = mode_ff[1] & mode_ff[2];

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awSeen_ff <= 1'b0;
      wSeen_ff  <= 1'b0;
      awa_ff    <= '0;
      wd_ff     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= host_port_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= host_port_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin awSeen_ff <= 1'b1; awa_ff <= s_axi_awaddr; end
      if (s_axi_wvalid && s_axi_wready) begin wSeen_ff <= 1'b1; wd_ff <= s_axi_wdata; end
      if (wrGo) begin
        awSeen_ff    <= 1'b0;
        wSeen_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // a command while a cycle runs is refused
        s_axi_bresp  <= (awa_ff == host_port_pkg::CMD_OFS && st_ff != IDLE) ? host_port_pkg::RESP_SLVERR
                      : host_port_pkg::RESP_OKAY;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= host_port_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          host_port_pkg::WDATA_OFS: s_axi_rdata <= {24'h00_0000, wdat_ff};
          host_port_pkg::RDATA_OFS: s_axi_rdata <= {24'h00_0000, rdat_ff};
          host_port_pkg::STAT_OFS:  s_axi_rdata <= {29'h0000_0000, hp.interruptOut, done_ff, st_ff != IDLE};
          host_port_pkg::MODE_OFS:  s_axi_rdata <= {25'h000_0000, devAddr_ff, mode_ff};
          host_port_pkg::CMD_OFS:   s_axi_rdata <= {27'h000_0000, rd_ff, addr_ff};
          default: begin s_axi_rdata <= '0; s_axi_rresp <= host_port_pkg::RESP_SLVERR; end
        endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_awready = ~awSeen_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~wSeen_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // ************************************************************
  // bus cycle sequencer
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RST; cnt_ff <= 16'(RST_CYC); addr_ff <= '0; wdat_ff <= '0; rdat_ff <= '0;
      rd_ff <= 1'b0; mode_ff <= 4'h1; devAddr_ff <= '0; done_ff <= 1'b0;
    end else begin
      if (wrGo && awa_ff == host_port_pkg::MODE_OFS && s_axi_wstrb[0]) begin
        mode_ff <= wd_ff[3:0]; devAddr_ff <= wd_ff[6:4];
      end
      if (wrGo && awa_ff == host_port_pkg::WDATA_OFS && s_axi_wstrb[0]) wdat_ff <= wd_ff[7:0];
      if (!cntZero) cnt_ff <= cnt_ff - 16'h0001;
      unique case (st_ff)
        RST:    if (cntZero) st_ff <= IDLE;
        IDLE:   if (wrGo && awa_ff == host_port_pkg::CMD_OFS) begin
                  addr_ff <= wd_ff[3:0]; rd_ff <= wd_ff[4]; done_ff <= 1'b0;
                  cnt_ff <= 16'(PHASE); st_ff <= ADDR;
                end
        ADDR:   if (cntZero) begin cnt_ff <= 16'(PHASE); st_ff <= LATCH; end
        LATCH:  if (cntZero) st_ff <= STROBE;
        STROBE: if (hsSeen) begin
                  if (rd_ff) rdat_ff <= hp.busLevel;
                  st_ff <= DONE;
                end
        DONE:   begin done_ff <= 1'b1; st_ff <= IDLE; end
        default: st_ff <= IDLE;
      endcase
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  logic inCycle;
  logic strobing;
  assign inCycle  = (st_ff == ADDR) || (st_ff == LATCH) || (st_ff == STROBE);
  assign strobing = (st_ff == STROBE);
  assign hp.hwResetN            = (st_ff != RST);
  assign hp.strobeStyleSelect   = mode_ff[0];
  assign hp.busMultiplexSelect  = mode_ff[1];
  assign hp.chipSelN            = useStrap ? 1'b0 : ~inCycle;
  assign hp.addrIn              = useStrap ? {1'b1, devAddr_ff}
                                 : (mode_ff[1] ? 4'h0 : addr_ff);
  assign hp.addressLatchStrobe  = (st_ff != ADDR);
  assign hp.writeOrDataStrobe   = ~(strobing & (~mode_ff[0] | ~rd_ff));
  assign hp.readOrDirection     = mode_ff[0] ? ~(strobing & rd_ff) : rd_ff;
  // address phase on the muxed bus, write data in the strobe phase, released on reads
  assign hp.busHostOut = (st_ff == ADDR || st_ff == LATCH) && mode_ff[1]
                       ? {1'b0, devAddr_ff, addr_ff} : wdat_ff;
  assign hp.busHostOe  = {8{(mode_ff[1] && (st_ff == ADDR || st_ff == LATCH)) || (strobing && !rd_ff)}};
endmodule
`default_nettype wire

//--- verif/host_port_chk.sv
// Purpose: pin protocol checks between the host end and the device end
// Assumes: every pin sampled on mclk
// Notes:   strap-select answers (mux with addrIn[3] high) are judged by the bench
`default_nettype none
module host_port_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       strobeStyleSelect,
  input wire logic       busMultiplexSelect,
  input wire logic       chipSelN,
  input wire logic       writeOrDataStrobe,
  input wire logic       readOrDirection,
  input wire logic [3:0] addrIn,
  input wire logic [7:0] busDevOe,
  input wire logic       handshakeOut,
  input wire logic       handshakeOe
);
  // ****************************************
  // strobe decode
  // ****************************************
  // style 0 reads need the direction line high
  wire rdSel    = strobeStyleSelect ? !readOrDirection : (!writeOrDataStrobe && readOrDirection);
  wire anyStb   = strobeStyleSelect ? !(readOrDirection && writeOrDataStrobe) : !writeOrDataStrobe;
  wire plainSel = !chipSelN && !(busMultiplexSelect && addrIn[3]);
  // done is ready high in style 1, ack low in style 0
  wire hsDone   = handshakeOe && (handshakeOut == strobeStyleSelect);
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // an operation opens when a strobe falls on a plainly selected port
  sequence sOpen;
    $rose(anyStb) && plainSel;
  endsequence
  sequence sHeld;
    hsDone && anyStb;
  endsequence
  a_ready_high: assert property (sOpen ##0 strobeStyleSelect |-> ##[1:3] hsDone)
    else $error("ready not raised after strobe");
  a_ack_low: assert property (sOpen ##0 !strobeStyleSelect |-> ##[1:3] hsDone)
    else $error("acknowledge not lowered after strobe");
  a_answer_holds: assert property (sHeld |=> hsDone)
    else $error("answer dropped while strobe low");
  a_done_needs_strobe: assert property (hsDone |-> anyStb || $past(anyStb) || $past(anyStb, 2))
    else $error("answer without an operation");
  a_cs_hs_off: assert property (chipSelN && $past(chipSelN) |-> !handshakeOe)
    else $error("handshake driven while deselected");
  a_cs_bus_off: assert property (chipSelN [*2] |-> busDevOe == 8'h00)
    else $error("bus driven while deselected");
  a_bus_read_only: assert property (busDevOe != 8'h00 |-> !$past(chipSelN) && (rdSel || $past(rdSel)))
    else $error("bus driven outside a read");
  a_read_drives: assert property (hsDone && rdSel && plainSel |-> busDevOe == 8'hFF)
    else $error("read answered without data");
endmodule
`default_nettype wire

//--- verif/host_bus_and_chip_control_tb.sv
// Purpose: bench joining the host end to the device end over the pin bundle
// Assumes: mclk 50 MHz; reference watchdog count shortened, reset pin held full length
// Notes:   style 1 with nobody answering completes on the pulled-up ready
`default_nettype none
module host_bus_and_chip_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, rst_n = 0, refClk = 0, refRun = 0, ictN = 1;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, lost, rateSel, testSel, lineClr, triOut;
  logic [7:0]  alarmEvent = 0, awaddr = 0, araddr = 0;
  logic [1:0]  alarmBank = 0, bresp, rresp, rsp;
  logic [31:0] wdata = 0, rdata, rd;
  int          n_errors = 0, cmp_count = 0;
  host_port_if hp();
  always #10 mclk = ~mclk;
  // reference clock stands still unless a test runs it
  always @(posedge mclk) if (refRun) refClk <= ~refClk;
  line_device_port #(.REF_LOST(16)) i_line_device_port (.mclk(mclk), .rst_n(rst_n), .hp(hp),
    .alarmEvent(alarmEvent), .alarmBank(alarmBank), .deviceAddress(3'h5), .recoveryReferenceClock(refClk),
    .in_circuit_test_n(ictN), .referenceClockLost(lost), .referenceRateSelect(rateSel),
    .testTristateSetSelect(testSel), .lineStateClear(lineClr), .outputsTristated(triOut));
  host_bus_master i_host_bus_master (.mclk(mclk), .rst_n(rst_n), .hp(hp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  host_port_chk i_host_port_chk (.mclk(mclk), .rst_n(rst_n), .strobeStyleSelect(hp.strobeStyleSelect),
    .busMultiplexSelect(hp.busMultiplexSelect), .chipSelN(hp.chipSelN), .addrIn(hp.addrIn),
    .writeOrDataStrobe(hp.writeOrDataStrobe), .readOrDirection(hp.readOrDirection),
    .busDevOe(hp.busDevOe), .handshakeOut(hp.handshakeOut), .handshakeOe(hp.handshakeOe));
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    rsp = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    rd = rdata;
    rsp = rresp;
  endtask
  task automatic setMode(input logic [7:0] m);
    axw(host_port_pkg::MODE_OFS, {24'h00_0000, m});
  endtask
  // one device cycle; a read leaves its byte in rd
  task automatic dev(input logic rdOp, input logic [3:0] a, input logic [7:0] d);
    axw(host_port_pkg::WDATA_OFS, {24'h00_0000, d});
    axw(host_port_pkg::CMD_OFS, {27'h000_0000, rdOp, a});
    do axr(host_port_pkg::STAT_OFS); while (rd[1:0] !== 2'b10);
    if (rdOp) axr(host_port_pkg::RDATA_OFS);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    repeat (495) @(posedge mclk);
    chk(hp.hwResetN, 0);
    chk(lineClr, 1);
    repeat (8) @(posedge mclk);
    chk(lineClr, 0);
  endtask
  // all four strobe and bus modes on the same register
  task automatic t_modes();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 8'h30 | 8'(i) | (i[0] ? 8'h08 : 8'h00);
      setMode(8'(i));
      dev(0, host_port_pkg::REG_TEST, d);
      dev(1, host_port_pkg::REG_TEST, 8'h00);
      chk(rd, {24'h00_0000, d});
      chk(testSel, d[3]);
    end
    axr(8'h14);
    chk(rsp, host_port_pkg::RESP_SLVERR);
  endtask
  // a foreign strap address must leave the register alone
  task automatic t_strap();
    setMode(8'h57);
    dev(0, host_port_pkg::REG_MASK1, 8'hA5);
    dev(1, host_port_pkg::REG_MASK1, 8'h00);
    chk(rd, 32'h0000_00A5);
    setMode(8'h27);
    dev(0, host_port_pkg::REG_MASK1, 8'h11);
    dev(1, host_port_pkg::REG_MASK1, 8'h00);
    chk(rd, 32'h0000_00FF);
    setMode(8'h57);
    dev(1, host_port_pkg::REG_MASK1, 8'h00);
    chk(rd, 32'h0000_00A5);
    dev(0, host_port_pkg::REG_MASK1, 8'h00);
  endtask
  task automatic t_irq();
    setMode(8'h01);
    alarmBank <= 2'b01;
    alarmEvent <= 8'h01;
    @(posedge mclk);
    alarmEvent <= 8'h00;
    repeat (3) @(posedge mclk);
    chk(hp.interruptOut, 1);
    dev(0, host_port_pkg::REG_MASK0, 8'h01);
    chk(hp.interruptOut, 0);
    dev(0, host_port_pkg::REG_MASK0, 8'h00);
    chk(hp.interruptOut, 1);
    dev(0, host_port_pkg::REG_ALARM0, 8'h01);
    chk(hp.interruptOut, 0);
  endtask
  task automatic t_clocks();
    dev(0, host_port_pkg::REG_CTRL, 8'h02);
    chk(rateSel, 1);
    dev(0, host_port_pkg::REG_CTRL, 8'h00);
    chk(rateSel, 0);
    refRun <= 1;
    repeat (40) @(posedge mclk);
    chk(lost, 0);
    refRun <= 0;
    repeat (40) @(posedge mclk);
    chk(lost, 1);
    ictN <= 0;
    repeat (3) @(posedge mclk);
    chk(triOut, 1);
    ictN <= 1;
    repeat (3) @(posedge mclk);
    chk(triOut, 0);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog: the whole run needs little over a thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    t_reset();
    t_modes();
    t_strap();
    t_irq();
    t_clocks();
    results();
  end
endmodule
`default_nettype wire
